/* dv/tb_on_chip_oscillator_clock_control.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) check_eq(32'(g), 32'(e), `__LINE__)
module tb_on_chip_oscillator_clock_control;
    localparam int HS_CYC = 8;
    logic                  hclk         = 1'b0;
    logic                  hresetn      = 1'b0;
    logic                  hsel         = 1'b0;
    logic [31:0]           haddr        = 32'h0;
    logic [1:0]            htrans       = 2'h0;
    logic                  hwrite       = 1'b0;
    logic [2:0]            hsize        = 3'h2;
    logic [31:0]           hwdata       = 32'h0;
    logic [7:0]            option_byte  = 8'h20;
    logic                  wdt_running  = 1'b0;
    logic                  hs_osc_ready = 1'b0;
    logic                  hreadyout;
    logic [31:0]           hrdata;
    logic                  hresp;
    osc_clk_pkg::osc_en_s  osc_en;
    osc_clk_pkg::clk_src_e fclk_src;
    logic                  cpu_reset_hold;
    logic [4:0]            hs_freq_mhz;
    logic                  hs_freq_bad;
    logic                  timer_clk_ls;
    logic                  wdt_ls_gate;
    logic                  sub_ultra_low;
    logic [31:0]           rd;
    int                    n_mismatch      = 0;
    int                    samples_checked = 0;

    // Free-running bus clock, 100 MHz
    always #5 hclk = ~hclk;

    // Short settle counts keep each reset cheap
    osc_clk_ctrl #(.HS_SETTLE_CYC(HS_CYC), .SETTLE_SHIFT(8)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .option_byte(option_byte), .wdt_running(wdt_running),
        .hs_osc_ready(hs_osc_ready), .osc_en(osc_en), .fclk_src(fclk_src),
        .cpu_reset_hold(cpu_reset_hold), .hs_freq_mhz(hs_freq_mhz),
        .hs_freq_bad(hs_freq_bad), .timer_clk_ls(timer_clk_ls),
        .wdt_ls_gate(wdt_ls_gate), .sub_ultra_low(sub_ultra_low));

    task automatic finish_test;
        $display("Mismatches %0d, checks %0d", n_mismatch, samples_checked);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic check_eq(input logic [31:0] g, e, input int l);
        samples_checked++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t line %0d got %0h exp %0h", $time, l, g, e);
        end
    endtask

    task automatic pause(input int n);
        repeat (n) @(posedge hclk);
        @(negedge hclk);
    endtask

    // Ready is taken at the rising edge, before the slave's update lands
    task automatic wait_rdy;
        int n;
        n = 0;
        do
        begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        if (hreadyout !== 1'b1)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // One single word transfer; read data lands in rd
    task automatic bus(input logic w, input logic [7:0] a, d);
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        wait_rdy();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        wait_rdy();
        rd = hrdata;
    endtask

    task automatic wait_src(input osc_clk_pkg::clk_src_e s, input int lim,
                            output int n);
        n = 0;
        while (fclk_src !== s && n < lim)
        begin
            @(negedge hclk);
            n++;
        end
        if (fclk_src !== s)
        begin
            n_mismatch++;
            finish_test();
        end
    endtask

    // Option byte is strapped while reset is low
    task automatic do_reset(input logic [7:0] opt);
        int n;
        @(posedge hclk);
        hresetn      <= 1'b0;
        option_byte  <= opt;
        hs_osc_ready <= 1'b0;
        pause(3);
        `CHK(osc_en, 4'h0);
        `CHK(cpu_reset_hold, 1'b1);
        @(posedge hclk);
        hresetn <= 1'b1;
        pause(2);
        `CHK(osc_en.hs, 1'b1);
        @(posedge hclk);
        hs_osc_ready <= 1'b1;
        n = 0;
        while (cpu_reset_hold !== 1'b0 && n < 200)
        begin
            @(negedge hclk);
            n++;
        end
        `CHK(n >= HS_CYC && n < 200, 1'b1);
        `CHK(fclk_src, osc_clk_pkg::SRC_HS);
        // A hold that never ends is a hang; report it at once
        if (cpu_reset_hold !== 1'b0)
            finish_test();
    endtask

    // Every valid code, then the prohibited code 4'hf last
    task automatic t_freq;
        logic [3:0] c [10] = '{4'h0, 4'h9, 4'h1, 4'ha, 4'h2,
                               4'hb, 4'h3, 4'hc, 4'hd, 4'hf};
        logic [4:0] m [10] = '{5'h18, 5'h10, 5'h0c, 5'h08, 5'h06,
                               5'h04, 5'h03, 5'h02, 5'h01, 5'h00};
        for (int i = 0; i < 10; i++)
        begin
            do_reset({4'h2, c[i]});
            `CHK(hs_freq_bad, i == 9);
            if (i < 9)
                `CHK(hs_freq_mhz, m[i]);
            bus(1'b0, osc_clk_pkg::OFF_OPTION, 8'h00);
            `CHK(rd, {23'h0, i == 9, 4'h2, c[i]});
        end
    endtask

    task automatic t_regs;
        do_reset(8'h20);
        bus(1'b0, osc_clk_pkg::OFF_OSC_CTRL, 8'h00);
        `CHK(rd, 32'h000000c0);
        `CHK(hresp, 1'b0);
        bus(1'b1, 8'h40, 8'hff);
        bus(1'b0, 8'h40, 8'h00);
        `CHK(rd, 32'h0);
        bus(1'b1, osc_clk_pkg::OFF_OSC_CTRL, 8'hc1);
        pause(3);
        `CHK(osc_en.hs, 1'b0);
        bus(1'b0, osc_clk_pkg::OFF_OSC_CTRL, 8'h00);
        `CHK(rd, 32'h000000c1);
        bus(1'b1, osc_clk_pkg::OFF_OSC_CTRL, 8'hc0);
        pause(3);
        `CHK(osc_en.hs, 1'b1);
        bus(1'b1, osc_clk_pkg::OFF_MODE, 8'h04);
        pause(3);
        `CHK(sub_ultra_low, 1'b1);
        bus(1'b1, osc_clk_pkg::OFF_MODE, 8'h02);
        pause(3);
        `CHK(sub_ultra_low, 1'b0);
    endtask

    // Watchdog sync adds latency, so allow a few edges
    task automatic t_ls;
        pause(5);
        `CHK(osc_en.ls, 1'b0);
        `CHK(timer_clk_ls, 1'b0);
        @(posedge hclk);
        wdt_running <= 1'b1;
        pause(5);
        `CHK(osc_en.ls, 1'b1);
        `CHK(wdt_ls_gate, 1'b1);
        @(posedge hclk);
        wdt_running <= 1'b0;
        bus(1'b1, osc_clk_pkg::OFF_SUPPLY, 8'h10);
        pause(5);
        `CHK(osc_en.ls, 1'b1);
        `CHK(timer_clk_ls, 1'b1);
        bus(1'b1, osc_clk_pkg::OFF_SUPPLY, 8'h00);
        pause(5);
        `CHK(osc_en.ls, 1'b0);
        `CHK(wdt_ls_gate, 1'b0);
    endtask

    // External clock first, then crystal with its settle wait
    task automatic t_x1;
        int n;
        do_reset(8'h20);
        bus(1'b1, osc_clk_pkg::OFF_MODE, 8'hc0);
        bus(1'b1, osc_clk_pkg::OFF_OSC_CTRL, 8'h40);
        bus(1'b1, osc_clk_pkg::OFF_SYS_SEL, 8'h10);
        wait_src(osc_clk_pkg::SRC_X1, 12, n);
        bus(1'b0, osc_clk_pkg::OFF_SETTLE, 8'h00);
        `CHK(rd, 32'h000000ff);
        do_reset(8'h20);
        bus(1'b1, osc_clk_pkg::OFF_MODE, 8'h40);
        bus(1'b1, osc_clk_pkg::OFF_OSC_CTRL, 8'h40);
        bus(1'b1, osc_clk_pkg::OFF_SYS_SEL, 8'h10);
        pause(4);
        `CHK(osc_en.x1, 1'b1);
        `CHK(fclk_src, osc_clk_pkg::SRC_HS);
        wait_src(osc_clk_pkg::SRC_X1, 2000, n);
        `CHK(n > 900, 1'b1);
        bus(1'b0, osc_clk_pkg::OFF_SETTLE, 8'h00);
        `CHK(rd, 32'h000000ff);
        bus(1'b0, osc_clk_pkg::OFF_SYS_SEL, 8'h00);
        `CHK(rd, 32'h00000030);
        bus(1'b1, osc_clk_pkg::OFF_MODE, 8'h50);
        bus(1'b1, osc_clk_pkg::OFF_OSC_CTRL, 8'h00);
        bus(1'b1, osc_clk_pkg::OFF_SYS_SEL, 8'h40);
        wait_src(osc_clk_pkg::SRC_SUB, 20, n);
        `CHK(osc_en.xt1, 1'b1);
    endtask

    initial
    begin
        t_freq();
        t_regs();
        t_ls();
        t_x1();
        finish_test();
    end
endmodule
`default_nettype wire

/* rtl/osc_clk_ctrl.sv */
`timescale 1ns/1ps
`default_nettype none
module osc_clk_ctrl #(
    parameter int HS_SETTLE_CYC =
        (osc_clk_pkg::HS_SETTLE_NS + osc_clk_pkg::CLK_PERIOD_NS - 1)
        / osc_clk_pkg::CLK_PERIOD_NS,
    parameter int SETTLE_SHIFT  = 0
) (
    input  wire logic                  hclk,
    input  wire logic                  hresetn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic [31:0]                hrdata,
    output logic                       hresp,
    input  wire logic [7:0]            option_byte,
    input  wire logic                  wdt_running,
    input  wire logic                  hs_osc_ready,
    output osc_clk_pkg::osc_en_s       osc_en,
    output osc_clk_pkg::clk_src_e      fclk_src,
    output logic                       cpu_reset_hold,
    output logic [4:0]                 hs_freq_mhz,
    output logic                       hs_freq_bad,
    output logic                       timer_clk_ls,
    output logic                       wdt_ls_gate,
    output logic                       sub_ultra_low
);
    localparam logic [15:0] HS_DONE = 16'(HS_SETTLE_CYC);
    localparam int          X1_CNT_W = osc_clk_pkg::X1_CNT_W;

    logic [9:0]                 sync_a_q;
    logic [9:0]                 sync_b_q;
    logic                       wdt_s;
    logic                       hs_rdy_s;
    logic [7:0]                 opt_s;
    logic                       wr_pend_q;
    logic [7:0]                 addr_q;
    logic [7:0]                 clock_op_status_ctrl_q;
    logic [7:0]                 mode_q;
    logic [7:0]                 subclock_supply_mode_ctrl_q;
    logic [7:0]                 sys_sel_q;
    logic [7:0]                 opt_q;
    logic [15:0]                hs_cnt_q;
    logic [X1_CNT_W-1:0]        x1_cnt_q;
    logic [7:0]                 settle_stat;
    osc_clk_pkg::boot_e         boot_q;
    osc_clk_pkg::osc_en_s       osc_en_q;
    osc_clk_pkg::clk_src_e      fclk_src_q;
    logic                       hold_q;
    logic [4:0]                 freq_q;
    logic                       bad_q;
    logic                       tmr_ls_q;
    logic                       wdt_gate_q;
    logic                       ultra_q;
    logic                       hreadyout_q;
    logic [31:0]                hrdata_q;
    logic                       hresp_q;
    logic                       low_speed_clock_select;
    logic                       x1_on;
    logic                       x1_ext;
    logic                       x1_stable;
    logic                       xt1_on;
    logic                       addr_take;
    // Register select, shared by the read and write paths
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction
    // Frequency field decode, bad flag in the top bit
    function automatic logic [5:0] freq_dec(input logic [3:0] code);
        case (code)
            osc_clk_pkg::FRQ_24: freq_dec = {1'b0, osc_clk_pkg::MHZ_24};
            osc_clk_pkg::FRQ_16: freq_dec = {1'b0, osc_clk_pkg::MHZ_16};
            osc_clk_pkg::FRQ_12: freq_dec = {1'b0, osc_clk_pkg::MHZ_12};
            osc_clk_pkg::FRQ_8:  freq_dec = {1'b0, osc_clk_pkg::MHZ_8};
            osc_clk_pkg::FRQ_6:  freq_dec = {1'b0, osc_clk_pkg::MHZ_6};
            osc_clk_pkg::FRQ_4:  freq_dec = {1'b0, osc_clk_pkg::MHZ_4};
            osc_clk_pkg::FRQ_3:  freq_dec = {1'b0, osc_clk_pkg::MHZ_3};
            osc_clk_pkg::FRQ_2:  freq_dec = {1'b0, osc_clk_pkg::MHZ_2};
            osc_clk_pkg::FRQ_1:  freq_dec = {1'b0, osc_clk_pkg::MHZ_1};
            default:             freq_dec = {1'b1, osc_clk_pkg::MHZ_24};
        endcase
    endfunction
    // Pins pass two flops; only the second stage is read
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            sync_a_q <= 10'h000;
            sync_b_q <= 10'h000;
        end
        else
        begin
            sync_a_q <= {wdt_running, hs_osc_ready, option_byte};
            sync_b_q <= sync_a_q;
        end
    end
    assign wdt_s    = sync_b_q[9];
    assign hs_rdy_s = sync_b_q[8];
    assign opt_s    = sync_b_q[7:0];
    // Derived oscillator states and the bus address strobe
    assign low_speed_clock_select =
        subclock_supply_mode_ctrl_q[osc_clk_pkg::SUP_LS_SEL];
    assign x1_on  = !clock_op_status_ctrl_q[osc_clk_pkg::CSC_X1_STOP]
                    && mode_q[osc_clk_pkg::MODE_X1_SEL];
    assign x1_ext = mode_q[osc_clk_pkg::MODE_EXT_MAIN];
    assign xt1_on = !clock_op_status_ctrl_q[osc_clk_pkg::CSC_XT1_STOP]
                    && mode_q[osc_clk_pkg::MODE_XT1_SEL];
    assign addr_take = hsel && hready && htrans[1];
    // Reset processing: hold the CPU until the fast clock has settled
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            boot_q   <= osc_clk_pkg::ST_HOLD;
            hold_q   <= 1'b1;
            hs_cnt_q <= 16'h0000;
            opt_q    <= 8'h00;
        end
        else
        begin
            case (boot_q)
                osc_clk_pkg::ST_HOLD:
                begin
                    opt_q <= opt_s; // Strap caught after release
                    if (hs_rdy_s) // CPU waits for fast clock output
                    begin
                        hs_cnt_q <= hs_cnt_q + 16'h0001;
                    end
                    if (hs_rdy_s && hs_cnt_q == HS_DONE - 16'h0001)
                    begin
                        boot_q <= osc_clk_pkg::ST_RUN;
                        hold_q <= 1'b0;
                    end
                end
                osc_clk_pkg::ST_RUN:
                begin
                    hold_q <= 1'b0;
                end
                default:
                begin
                    boot_q <= osc_clk_pkg::ST_HOLD;
                end
            endcase
        end
    end
    // Bus address phase; zero wait, so the read data is ready at once
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q   <= 1'b0;
            addr_q      <= 8'h00;
            hrdata_q    <= 32'h0000_0000;
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            hresp_q     <= 1'b0;
            wr_pend_q   <= addr_take && hwrite;
            if (addr_take)
            begin
                addr_q <= haddr[7:0];
            end
            hrdata_q <= 32'h0000_0000;
            if (addr_take && !hwrite)
            begin
                if (hit(haddr[7:0], osc_clk_pkg::OFF_OSC_CTRL))
                    hrdata_q[7:0] <= clock_op_status_ctrl_q;
                if (hit(haddr[7:0], osc_clk_pkg::OFF_MODE))
                    hrdata_q[7:0] <= mode_q;
                if (hit(haddr[7:0], osc_clk_pkg::OFF_SUPPLY))
                    hrdata_q[7:0] <= subclock_supply_mode_ctrl_q;
                if (hit(haddr[7:0], osc_clk_pkg::OFF_SYS_SEL))
                    hrdata_q[7:0] <= sys_sel_q;
                if (hit(haddr[7:0], osc_clk_pkg::OFF_SETTLE))
                    hrdata_q[7:0] <= settle_stat;
                if (hit(haddr[7:0], osc_clk_pkg::OFF_OPTION))
                    hrdata_q[osc_clk_pkg::OPT_BAD_BIT:0] <= {bad_q, opt_q};
            end
        end
    end
    // Data phase writes; unmapped offsets and reserved bits are dropped
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            clock_op_status_ctrl_q      <= osc_clk_pkg::CSC_RESET;
            mode_q                      <= osc_clk_pkg::MODE_RESET;
            subclock_supply_mode_ctrl_q <= osc_clk_pkg::SUP_RESET;
            sys_sel_q                   <= osc_clk_pkg::SEL_RESET;
        end
        else
        begin
            if (wr_pend_q && hit(addr_q, osc_clk_pkg::OFF_OSC_CTRL))
                clock_op_status_ctrl_q <=
                    hwdata[7:0] & osc_clk_pkg::CSC_MASK;
            if (wr_pend_q && hit(addr_q, osc_clk_pkg::OFF_MODE))
                mode_q <= hwdata[7:0] & osc_clk_pkg::MODE_MASK;
            if (wr_pend_q && hit(addr_q, osc_clk_pkg::OFF_SUPPLY))
                subclock_supply_mode_ctrl_q <=
                    hwdata[7:0] & osc_clk_pkg::SUP_MASK;
            // Status bits mirror the clock actually in use
            sys_sel_q[osc_clk_pkg::SEL_X1_STAT] <=
                (fclk_src_q == osc_clk_pkg::SRC_X1);
            sys_sel_q[osc_clk_pkg::SEL_SUB_STAT] <=
                (fclk_src_q == osc_clk_pkg::SRC_SUB);
            if (wr_pend_q && hit(addr_q, osc_clk_pkg::OFF_SYS_SEL))
            begin
                sys_sel_q[osc_clk_pkg::SEL_X1] <=
                    hwdata[osc_clk_pkg::SEL_X1];
                sys_sel_q[osc_clk_pkg::SEL_SUB] <=
                    hwdata[osc_clk_pkg::SEL_SUB];
            end
        end
    end
    // X1 settle count; hclk stands in for the X1 edges
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            x1_cnt_q <= '0;
        else if (!x1_on || x1_ext)
            x1_cnt_q <= '0;
        else if (x1_cnt_q != '1)
            x1_cnt_q <= x1_cnt_q + X1_CNT_W'(1);
    end
    // Thermometer status, forced full for an external clock
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++)
        begin : g_settle
            localparam int EXP = osc_clk_pkg::SETTLE_EXP[gi] - SETTLE_SHIFT;
            assign settle_stat[gi] = (x1_on && x1_ext)
                || (x1_cnt_q >= X1_CNT_W'(1 << EXP));
        end
    endgenerate
    assign x1_stable = settle_stat[0];
    // Oscillator enables and clock routing
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            osc_en_q   <= '0;
            tmr_ls_q   <= 1'b0;
            wdt_gate_q <= 1'b0;
            ultra_q    <= 1'b0;
            freq_q     <= osc_clk_pkg::MHZ_24;
            bad_q      <= 1'b0;
        end
        else
        begin
            osc_en_q.hs  <=
                !clock_op_status_ctrl_q[osc_clk_pkg::CSC_HS_STOP];
            osc_en_q.x1  <= x1_on && !x1_ext;
            osc_en_q.xt1 <= xt1_on && !mode_q[osc_clk_pkg::MODE_EXT_SUB];
            osc_en_q.ls  <= wdt_s || low_speed_clock_select;
            // Slow clock only to watchdog and timers
            wdt_gate_q <= wdt_s;
            tmr_ls_q   <= low_speed_clock_select;
            ultra_q    <= {mode_q[osc_clk_pkg::MODE_AMP_HI],
                           mode_q[osc_clk_pkg::MODE_AMP_LO]}
                          == osc_clk_pkg::AMP_ULTRA;
            {bad_q, freq_q} <= freq_dec(opt_q[3:0]);
        end
    end
    // CPU clock source; a request waits until its oscillator is usable
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            fclk_src_q <= osc_clk_pkg::SRC_HS;
        else if (hold_q)
            fclk_src_q <= osc_clk_pkg::SRC_HS;
        else if (sys_sel_q[osc_clk_pkg::SEL_SUB] && xt1_on)
            fclk_src_q <= osc_clk_pkg::SRC_SUB;
        else if (!sys_sel_q[osc_clk_pkg::SEL_SUB]
                 && sys_sel_q[osc_clk_pkg::SEL_X1] && x1_on && x1_stable)
            fclk_src_q <= osc_clk_pkg::SRC_X1;
        else if (!sys_sel_q[osc_clk_pkg::SEL_SUB]
                 && !sys_sel_q[osc_clk_pkg::SEL_X1] && osc_en_q.hs)
            fclk_src_q <= osc_clk_pkg::SRC_HS;
    end
    assign hreadyout      = hreadyout_q;
    assign hrdata         = hrdata_q;
    assign hresp          = hresp_q;
    assign osc_en         = osc_en_q;
    assign fclk_src       = fclk_src_q;
    assign cpu_reset_hold = hold_q;
    assign hs_freq_mhz    = freq_q;
    assign hs_freq_bad    = bad_q;
    assign timer_clk_ls   = tmr_ls_q;
    assign wdt_ls_gate    = wdt_gate_q;
    assign sub_ultra_low  = ultra_q;
    // Checks on the block's own outputs
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_hs_stop;
        clock_op_status_ctrl_q[osc_clk_pkg::CSC_HS_STOP] |=> !osc_en_q.hs;
    endproperty
    a_hs_stop: assert property (p_hs_stop)
        else $error("fast osc still on after stop");
    property p_hs_write;
        wr_pend_q && hit(addr_q, osc_clk_pkg::OFF_OSC_CTRL)
            && !hwdata[osc_clk_pkg::CSC_HS_STOP] |=> ##1 osc_en_q.hs;
    endproperty
    a_hs_write: assert property (p_hs_write)
        else $error("fast osc not started by write");
    property p_ls_on;
        (wdt_s || low_speed_clock_select) |=> osc_en_q.ls;
    endproperty
    a_ls_on: assert property (p_ls_on)
        else $error("slow osc off while needed");
    property p_ls_off;
        (!wdt_s && !low_speed_clock_select) |=> !osc_en_q.ls;
    endproperty
    a_ls_off: assert property (p_ls_off)
        else $error("slow osc on while unused");
    // Gate must follow the watchdog, with the slow osc running under it
    property p_wdt_gate;
        wdt_s |=> wdt_gate_q && osc_en_q.ls;
    endproperty
    a_wdt_gate: assert property (p_wdt_gate)
        else $error("watchdog gate not following watchdog");
    property p_boot_src;
        hold_q |-> fclk_src_q == osc_clk_pkg::SRC_HS && osc_en_q.x1 == 1'b0;
    endproperty
    a_boot_src: assert property (p_boot_src)
        else $error("CPU clock not fast osc in reset processing");
    property p_hold_len;
        $fell(hold_q) |-> hs_cnt_q == HS_DONE && $past(hs_rdy_s);
    endproperty
    a_hold_len: assert property (p_hold_len)
        else $error("reset processing ended early");
    property p_freq16;
        !hold_q && opt_q[3:0] == osc_clk_pkg::FRQ_16 |=>
            freq_q == osc_clk_pkg::MHZ_16 && !bad_q;
    endproperty
    a_freq16: assert property (p_freq16)
        else $error("16 MHz code decoded wrong");
    // Checked through the bus so a broken read path is caught too
    property p_ext_settle;
        addr_take && !hwrite && hit(haddr[7:0], osc_clk_pkg::OFF_SETTLE)
            && x1_on && x1_ext |=> hrdata_q[7:0] == 8'hff;
    endproperty
    a_ext_settle: assert property (p_ext_settle)
        else $error("external clock shows settle wait");
    property p_ultra;
        ({mode_q[osc_clk_pkg::MODE_AMP_HI], mode_q[osc_clk_pkg::MODE_AMP_LO]}
            == osc_clk_pkg::AMP_ULTRA) [*2] |-> ultra_q;
    endproperty
    a_ultra: assert property (p_ultra)
        else $error("ultra low mode not selected");
    property p_tmr_sel;
        $changed(low_speed_clock_select) |=>
            tmr_ls_q == $past(low_speed_clock_select);
    endproperty
    a_tmr_sel: assert property (p_tmr_sel)
        else $error("timer clock select lags");
    c_hs_stop: cover property ($fell(osc_en_q.hs));
    c_x1_run:  cover property (fclk_src_q == osc_clk_pkg::SRC_X1);
    c_ls_wdt:  cover property (wdt_s && !low_speed_clock_select ##1 osc_en_q.ls);
    c_boot:    cover property ($fell(hold_q));
endmodule
`default_nettype wire

/* rtl/osc_clk_pkg.sv */
`default_nettype none
package osc_clk_pkg;
    // Register byte offsets
    localparam logic [7:0] OFF_OSC_CTRL = 8'h00;
    localparam logic [7:0] OFF_MODE     = 8'h04;
    localparam logic [7:0] OFF_SUPPLY   = 8'h08;
    localparam logic [7:0] OFF_SYS_SEL  = 8'h0c;
    localparam logic [7:0] OFF_SETTLE   = 8'h10;
    localparam logic [7:0] OFF_OPTION   = 8'h14;
    // Oscillator control fields
    localparam int CSC_X1_STOP  = 7;
    localparam int CSC_XT1_STOP = 6;
    localparam int CSC_HS_STOP  = 0;
    localparam logic [7:0] CSC_RESET = 8'hc0;
    localparam logic [7:0] CSC_MASK  = 8'hc1;
    // Clock mode fields
    localparam int MODE_EXT_MAIN = 7;
    localparam int MODE_X1_SEL   = 6;
    localparam int MODE_EXT_SUB  = 5;
    localparam int MODE_XT1_SEL  = 4;
    localparam int MODE_AMP_HI   = 2;
    localparam int MODE_AMP_LO   = 1;
    localparam logic [7:0] MODE_RESET = 8'h00;
    localparam logic [7:0] MODE_MASK  = 8'hf7;
    localparam logic [1:0] AMP_ULTRA  = 2'h2;
    // Subsystem supply fields
    localparam int SUP_LS_SEL = 4;
    localparam logic [7:0] SUP_RESET = 8'h00;
    localparam logic [7:0] SUP_MASK  = 8'h90;
    // System clock select fields
    localparam int SEL_SUB_STAT = 7;
    localparam int SEL_SUB      = 6;
    localparam int SEL_X1_STAT  = 5;
    localparam int SEL_X1       = 4;
    localparam logic [7:0] SEL_RESET = 8'h00;
    localparam logic [7:0] SEL_MASK  = 8'h50;
    // Option byte status
    localparam int OPT_BAD_BIT = 8;
    // Frequency codes and rates
    localparam logic [3:0] FRQ_24 = 4'h0;
    localparam logic [3:0] FRQ_16 = 4'h9;
    localparam logic [3:0] FRQ_12 = 4'h1;
    localparam logic [3:0] FRQ_8  = 4'ha;
    localparam logic [3:0] FRQ_6  = 4'h2;
    localparam logic [3:0] FRQ_4  = 4'hb;
    localparam logic [3:0] FRQ_3  = 4'h3;
    localparam logic [3:0] FRQ_2  = 4'hc;
    localparam logic [3:0] FRQ_1  = 4'hd;
    localparam logic [4:0] MHZ_24 = 5'h18;
    localparam logic [4:0] MHZ_16 = 5'h10;
    localparam logic [4:0] MHZ_12 = 5'h0c;
    localparam logic [4:0] MHZ_8  = 5'h08;
    localparam logic [4:0] MHZ_6  = 5'h06;
    localparam logic [4:0] MHZ_4  = 5'h04;
    localparam logic [4:0] MHZ_3  = 5'h03;
    localparam logic [4:0] MHZ_2  = 5'h02;
    localparam logic [4:0] MHZ_1  = 5'h01;
    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int HS_SETTLE_NS  = 10000;
    localparam int X1_CNT_W      = 19;
    // Settle status bit i shows 2**(SETTLE_EXP[i] - SETTLE_SHIFT) clocks elapsed
    localparam int SETTLE_EXP [8] = '{18, 17, 15, 13, 11, 10, 9, 8};
    typedef enum logic [1:0] {SRC_HS, SRC_X1, SRC_SUB} clk_src_e;
    typedef enum logic {ST_HOLD, ST_RUN} boot_e;
    typedef struct packed {
        logic hs;
        logic x1;
        logic xt1;
        logic ls;
    } osc_en_s;
endpackage
`default_nettype wire
